/* File: crbrf_regfile.v */
// Banked architectural register file with APB debug access
//
// Implementation choices: the placing of the registers and the APB interface to the registers.
`default_nettype none
`include "crbrf_defines.vh"

module crbrf_regfile (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  input  wire        manual_reset,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // Operand read ports
  input  wire [3:0]  op_a_idx,
  input  wire [3:0]  op_b_idx,
  output reg  [31:0] op_a_data,
  output reg  [31:0] op_b_data,
  // General register write port
  input  wire        gw_en,
  input  wire [3:0]  gw_idx,
  input  wire [31:0] gw_data,
  // Special register access port
  input  wire        sp_re,
  input  wire        sp_we,
  input  wire [4:0]  sp_sel,
  input  wire [31:0] sp_wdata,
  output reg  [31:0] sp_rdata,
  output reg         priv_violation,
  // Program flow
  input  wire        pc_load,
  input  wire [31:0] pc_next,
  input  wire        exc_entry,
  input  wire [31:0] exc_offset,
  input  wire        exc_return,
  output reg  [31:0] instruction_pointer,
  output reg  [31:0] status_word
);

  reg  [31:0] gpr [0:`CRBRF_GPR_LAST];
  reg  [31:0] global_base_reg;
  reg  [31:0] saved_status_reg;
  reg  [31:0] saved_pc_reg;
  reg  [31:0] vector_base_reg;
  reg  [31:0] mult_acc_high;
  reg  [31:0] mult_acc_low;
  reg  [31:0] procedure_return_reg;
  reg         apb_err;
  reg  [31:0] next_sp_rdata;
  reg         next_violation;
  reg  [31:0] next_prdata;
  reg         next_err;

  wire        privilege_bit   = status_word[`CRBRF_SR_MD];
  wire        bank_select_bit = status_word[`CRBRF_SR_RB];
  wire        active_bank     = privilege_bit & bank_select_bit;
  wire [9:0]  widx            = paddr[11:2];
  wire        apb_wr          = psel & penable & pwrite;
  wire        sp_bank         = (sp_sel[4:3] == `CRBRF_SEL_BANK);
  wire        sp_privonly     = (sp_sel == `CRBRF_SEL_SR) | (sp_sel == `CRBRF_SEL_SSR) |
                                (sp_sel == `CRBRF_SEL_SPC) | (sp_sel == `CRBRF_SEL_VBR) |
                                sp_bank;
  wire        sp_ok           = privilege_bit | ~sp_privonly;
  wire        sp_wr           = sp_we & sp_ok;
  wire [31:0] sr_masked       = sp_wdata & `CRBRF_SR_WMASK;

  // ----------------------------------------------------------------
  // Bank mapping
  // ----------------------------------------------------------------
  // Physical slot: bank 0 at 0-7, bank 1 at 8-15, shared 8-15 at 16-23
  function [4:0] crbrf_phys;
    input [3:0] idx;
    input       bank;
    begin
      if (idx[3]) begin
        crbrf_phys = {2'h2, idx[2:0]};
      end else begin
        crbrf_phys = {1'b0, bank, idx[2:0]};
      end
    end
  endfunction

  wire [4:0] gw_slot = crbrf_phys(gw_idx, active_bank);
  wire [4:0] sp_slot = crbrf_phys({1'b0, sp_sel[2:0]}, ~active_bank);

  // ----------------------------------------------------------------
  // General registers
  // ----------------------------------------------------------------
  genvar e;
  generate
    for (e = 0; e < `CRBRF_GPR_COUNT; e = e + 1) begin : g_gpr
      always @(posedge pclk) begin
        if (gw_en && gw_slot == e) begin
          gpr[e] <= gw_data;
        end else if (sp_wr && sp_bank && sp_slot == e) begin
          gpr[e] <= sp_wdata;
        end else if (apb_wr && widx == e) begin
          gpr[e] <= pwdata;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers without reset value
  // ----------------------------------------------------------------
  always @(posedge pclk) begin
    if (sp_wr && sp_sel == `CRBRF_SEL_GBR) begin
      global_base_reg <= sp_wdata;
    end else if (apb_wr && widx == `CRBRF_W_GBR) begin
      global_base_reg <= pwdata;
    end
    if (sp_wr && sp_sel == `CRBRF_SEL_MULT_ACC_HIGH) begin
      mult_acc_high <= sp_wdata;
    end else if (apb_wr && widx == `CRBRF_W_MULT_ACC_HIGH) begin
      mult_acc_high <= pwdata;
    end
    if (sp_wr && sp_sel == `CRBRF_SEL_MULT_ACC_LOW) begin
      mult_acc_low <= sp_wdata;
    end else if (apb_wr && widx == `CRBRF_W_MULT_ACC_LOW) begin
      mult_acc_low <= pwdata;
    end
    if (sp_wr && sp_sel == `CRBRF_SEL_PR) begin
      procedure_return_reg <= sp_wdata;
    end else if (apb_wr && widx == `CRBRF_W_PR) begin
      procedure_return_reg <= pwdata;
    end
    if (exc_entry) begin
      saved_status_reg <= status_word;
      saved_pc_reg     <= instruction_pointer;
    end else begin
      if (sp_wr && sp_sel == `CRBRF_SEL_SSR) begin
        saved_status_reg <= sp_wdata;
      end else if (apb_wr && widx == `CRBRF_W_SSR) begin
        saved_status_reg <= pwdata;
      end
      if (sp_wr && sp_sel == `CRBRF_SEL_SPC) begin
        saved_pc_reg <= sp_wdata;
      end else if (apb_wr && widx == `CRBRF_W_SPC) begin
        saved_pc_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Registers with reset value
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_word         <= `CRBRF_SR_RESET;
      vector_base_reg     <= `CRBRF_VBR_RESET;
      instruction_pointer <= `CRBRF_PC_RESET;
    end else if (manual_reset) begin
      status_word         <= `CRBRF_SR_RESET;
      vector_base_reg     <= `CRBRF_VBR_RESET;
      instruction_pointer <= `CRBRF_PC_RESET;
    end else begin
      if (exc_entry) begin
        status_word[`CRBRF_SR_MD] <= 1'b1;
        status_word[`CRBRF_SR_RB] <= 1'b1;
        status_word[`CRBRF_SR_BL] <= 1'b1;
        instruction_pointer       <= vector_base_reg + exc_offset;
      end else if (exc_return) begin
        status_word         <= saved_status_reg & `CRBRF_SR_WMASK;
        instruction_pointer <= saved_pc_reg;
      end else begin
        if (sp_wr && sp_sel == `CRBRF_SEL_SR) begin
          status_word <= sr_masked;
        end else if (apb_wr && widx == `CRBRF_W_SR) begin
          status_word <= pwdata & `CRBRF_SR_WMASK;
        end
        if (pc_load) begin
          instruction_pointer <= pc_next;
        end else if (apb_wr && widx == `CRBRF_W_PC) begin
          instruction_pointer <= pwdata;
        end
      end
      if (sp_wr && sp_sel == `CRBRF_SEL_VBR) begin
        vector_base_reg <= sp_wdata;
      end else if (apb_wr && widx == `CRBRF_W_VBR) begin
        vector_base_reg <= pwdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Read multiplexers
  // ----------------------------------------------------------------
  always @* begin
    next_violation = (sp_re | sp_we) & ~sp_ok;
    next_sp_rdata  = `CRBRF_ZERO;
    if (sp_re && sp_ok) begin
      if (sp_bank) begin
        next_sp_rdata = gpr[sp_slot];
      end else if (sp_sel == `CRBRF_SEL_SR) begin
        next_sp_rdata = status_word;
      end else if (sp_sel == `CRBRF_SEL_GBR) begin
        next_sp_rdata = global_base_reg;
      end else if (sp_sel == `CRBRF_SEL_SSR) begin
        next_sp_rdata = saved_status_reg;
      end else if (sp_sel == `CRBRF_SEL_SPC) begin
        next_sp_rdata = saved_pc_reg;
      end else if (sp_sel == `CRBRF_SEL_VBR) begin
        next_sp_rdata = vector_base_reg;
      end else if (sp_sel == `CRBRF_SEL_MULT_ACC_HIGH) begin
        next_sp_rdata = mult_acc_high;
      end else if (sp_sel == `CRBRF_SEL_MULT_ACC_LOW) begin
        next_sp_rdata = mult_acc_low;
      end else if (sp_sel == `CRBRF_SEL_PR) begin
        next_sp_rdata = procedure_return_reg;
      end else if (sp_sel == `CRBRF_SEL_PC) begin
        next_sp_rdata = instruction_pointer + `CRBRF_PC_AHEAD;
      end
    end
  end

  always @* begin
    next_err    = 1'b0;
    next_prdata = `CRBRF_ZERO;
    if (widx < `CRBRF_GPR_COUNT) begin
      next_prdata = gpr[widx[4:0]];
    end else if (widx == `CRBRF_W_SR) begin
      next_prdata = status_word;
    end else if (widx == `CRBRF_W_GBR) begin
      next_prdata = global_base_reg;
    end else if (widx == `CRBRF_W_SSR) begin
      next_prdata = saved_status_reg;
    end else if (widx == `CRBRF_W_SPC) begin
      next_prdata = saved_pc_reg;
    end else if (widx == `CRBRF_W_VBR) begin
      next_prdata = vector_base_reg;
    end else if (widx == `CRBRF_W_MULT_ACC_HIGH) begin
      next_prdata = mult_acc_high;
    end else if (widx == `CRBRF_W_MULT_ACC_LOW) begin
      next_prdata = mult_acc_low;
    end else if (widx == `CRBRF_W_PR) begin
      next_prdata = procedure_return_reg;
    end else if (widx == `CRBRF_W_PC) begin
      next_prdata = instruction_pointer;
    end else begin
      next_err = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      op_a_data      <= `CRBRF_ZERO;
      op_b_data      <= `CRBRF_ZERO;
      sp_rdata       <= `CRBRF_ZERO;
      priv_violation <= 1'b0;
      prdata         <= `CRBRF_ZERO;
      apb_err        <= 1'b0;
    end else begin
      op_a_data      <= gpr[crbrf_phys(op_a_idx, active_bank)];
      op_b_data      <= gpr[crbrf_phys(op_b_idx, active_bank)];
      sp_rdata       <= next_sp_rdata;
      priv_violation <= next_violation;
      if (psel && !penable) begin
        prdata  <= pwrite ? `CRBRF_ZERO : next_prdata;
        apb_err <= next_err;
      end
    end
  end

  assign pready  = psel & penable;
  assign pslverr = psel & penable & apb_err;

endmodule
`default_nettype wire

/* File: crbrf_defines.vh */
// Constants for the banked processor register file
`ifndef CRBRF_DEFINES_VH
`define CRBRF_DEFINES_VH

// ----------------------------------------------------------------
// Reset values, status write mask and PC read offset
// ----------------------------------------------------------------
`define CRBRF_PC_RESET     32'ha0000000
`define CRBRF_VBR_RESET    32'h00000000
`define CRBRF_SR_RESET     32'h700000f0
`define CRBRF_SR_WMASK     32'h700003f3
`define CRBRF_ZERO         32'h00000000
`define CRBRF_PC_AHEAD     32'h00000004

// ----------------------------------------------------------------
// Status word fields
// ----------------------------------------------------------------
`define CRBRF_SR_MD        30
`define CRBRF_SR_RB        29
`define CRBRF_SR_BL        28

// ----------------------------------------------------------------
// Storage layout
// ----------------------------------------------------------------
`define CRBRF_GPR_COUNT    24
`define CRBRF_GPR_LAST     23

// ----------------------------------------------------------------
// Special access selector codes
// ----------------------------------------------------------------
`define CRBRF_SEL_SR       5'h00
`define CRBRF_SEL_GBR      5'h01
`define CRBRF_SEL_SSR      5'h02
`define CRBRF_SEL_SPC      5'h03
`define CRBRF_SEL_VBR      5'h04
`define CRBRF_SEL_MULT_ACC_HIGH     5'h05
`define CRBRF_SEL_MULT_ACC_LOW     5'h06
`define CRBRF_SEL_PR       5'h07
`define CRBRF_SEL_BANK     2'h1
`define CRBRF_SEL_PC       5'h10

// ----------------------------------------------------------------
// APB word indices (byte address = index * 4)
// ----------------------------------------------------------------
`define CRBRF_W_SR         10'h018
`define CRBRF_W_GBR        10'h019
`define CRBRF_W_SSR        10'h01a
`define CRBRF_W_SPC        10'h01b
`define CRBRF_W_VBR        10'h01c
`define CRBRF_W_MULT_ACC_HIGH       10'h01d
`define CRBRF_W_MULT_ACC_LOW       10'h01e
`define CRBRF_W_PR         10'h01f
`define CRBRF_W_PC         10'h020

`endif

/* File: crbrf_asserts.sv */
// Checker for the register file ports
`default_nettype none
`include "crbrf_defines.vh"
module crbrf_asserts (
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        manual_reset,
  // Bus side
  input wire logic        penable,
  // Core side
  input wire logic        sp_re,
  input wire logic        sp_we,
  input wire logic [4:0]  sp_sel,
  input wire logic        exc_entry,
  input wire logic        exc_return,
  input wire logic [31:0] sp_rdata,
  input wire logic        priv_violation,
  input wire logic [31:0] instruction_pointer,
  input wire logic [31:0] status_word
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire logic usr = !status_word[`CRBRF_SR_MD];
  wire logic acc = sp_re || sp_we;
  wire logic prv = sp_sel inside {5'h00, 5'h02, 5'h03, 5'h04} || sp_sel[4:3] == 2'h1;
  chk_reset_pc: assert property (
    $rose(presetn) |-> instruction_pointer == `CRBRF_PC_RESET)
    else $error("pc reset value wrong");
  chk_reset_sr: assert property (
    $rose(presetn) |-> status_word == `CRBRF_SR_RESET)
    else $error("status reset value wrong");
  chk_manual_vals: assert property (
    manual_reset |=> status_word == `CRBRF_SR_RESET && instruction_pointer == `CRBRF_PC_RESET)
    else $error("manual reset values wrong");
  chk_exc_bank: assert property (
    exc_entry && !manual_reset |=> status_word[30:28] == 3'h7)
    else $error("exception entry bits not set");
  chk_user_refuse: assert property (
    acc && usr && prv |=> priv_violation && sp_rdata == 32'h0)
    else $error("user access not refused");
  chk_open_access: assert property (
    acc && sp_sel inside {5'h01, 5'h05, 5'h06, 5'h07} |=> !priv_violation)
    else $error("open register refused");
  chk_pc_ahead: assert property (
    sp_re && sp_sel == 5'h10 |=> sp_rdata == $past(instruction_pointer) + 32'h4)
    else $error("pc operand wrong");
  chk_sr_kept: assert property (
    sp_we && usr && sp_sel == 5'h00 && !manual_reset && !exc_entry && !exc_return && !penable
    |=> $stable(status_word))
    else $error("status changed by user");
endmodule
bind crbrf_regfile crbrf_asserts i_chk (
  .pclk(pclk), .presetn(presetn), .manual_reset(manual_reset), .penable(penable),
  .sp_re(sp_re), .sp_we(sp_we), .sp_sel(sp_sel), .exc_entry(exc_entry),
  .exc_return(exc_return), .sp_rdata(sp_rdata), .priv_violation(priv_violation),
  .instruction_pointer(instruction_pointer), .status_word(status_word)
);
`default_nettype wire

/* File: crbrf_core_model.sv */
// Model of the core execution logic
`default_nettype none
module crbrf_core_model (
  // Clock
  input  wire logic        pclk,
  // Core requests
  output var  logic [3:0]  op_a_idx,
  output var  logic [3:0]  op_b_idx,
  output var  logic        gw_en,
  output var  logic [3:0]  gw_idx,
  output var  logic [31:0] gw_data,
  output var  logic        sp_re,
  output var  logic        sp_we,
  output var  logic [4:0]  sp_sel,
  output var  logic [31:0] sp_wdata,
  output var  logic        pc_load,
  output var  logic [31:0] pc_next,
  output var  logic        exc_entry,
  output var  logic [31:0] exc_offset,
  output var  logic        exc_return
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {op_a_idx, op_b_idx, gw_idx, sp_sel} = '0;
    {sp_re, sp_we, pc_load, exc_entry, exc_return, gw_en} = '0;
    {gw_data, sp_wdata, pc_next, exc_offset} = '0;
  end
  // One request held for one edge, then data inverted
  task automatic drive(input int k, input logic [4:0] s, input logic [31:0] v);
    @(posedge pclk);
    {sp_re, sp_we, pc_load, exc_entry, exc_return, gw_en} <= 6'h20 >> k;
    {gw_data, sp_wdata, pc_next, exc_offset} <= {4{v}};
    sp_sel <= s;
    gw_idx <= s[3:0];
    op_a_idx <= s[3:0];
    op_b_idx <= v[3:0];
    @(posedge pclk);
    {sp_re, sp_we, pc_load, exc_entry, exc_return, gw_en} <= 6'h00;
    {gw_data, sp_wdata, pc_next, exc_offset} <= {4{~v}};
  endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
// Bench for the banked register file
`default_nettype none
`include "crbrf_defines.vh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, manual_reset = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata, op_a_data, op_b_data, sp_rdata, instruction_pointer, status_word;
  logic [31:0] gw_data, sp_wdata, pc_next, exc_offset, rd, d, pcv, vbv, m_sr;
  logic [3:0]  op_a_idx, op_b_idx, gw_idx;
  logic [4:0]  sp_sel;
  logic        pready, pslverr, priv_violation, gw_en, sp_re, sp_we;
  logic        pc_load, exc_entry, exc_return, err, prv;
  logic [31:0] m_gpr [24];
  logic [31:0] srv [3] = '{32'h600000f0, 32'h400000f0, 32'h200000f0};
  int          failures = 0, n_compared = 0;
  always #2 pclk = ~pclk;
  crbrf_regfile    i_dut (.*);
  crbrf_core_model i_core (.*);
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {a, 2'h0};
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask
  task automatic rdchk(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    check(rd, e);
  endtask
  task automatic sp(input int k, input logic [4:0] s, input logic [31:0] v);
    i_core.drive(k, s, v);
    @(negedge pclk);
  endtask
  function automatic logic [31:0] opnd(input int j);
    return j < 8 ? m_gpr[(m_sr[30] & m_sr[29]) * 8 + j] : m_gpr[j + 8];
  endfunction
  task automatic close_out;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #50us;
    failures++;
    close_out();
  end
  initial begin
    void'($urandom(95));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check(status_word, `CRBRF_SR_RESET);
    check(instruction_pointer, `CRBRF_PC_RESET);
    rdchk(`CRBRF_W_VBR, `CRBRF_VBR_RESET);
    apb(1'b1, 10'h021, $urandom);
    check({31'h0, err}, 32'h1);
    $display("test reset end");
    for (int i = 0; i < 24; i++) begin
      m_gpr[i] = $urandom;
      apb(1'b1, i[9:0], m_gpr[i]);
    end
    foreach (srv[k]) begin
      m_sr = srv[k];
      apb(1'b1, `CRBRF_W_SR, m_sr);
      check(status_word, m_sr);
      d = $urandom;
      sp(5, 5'h02, d);
      m_gpr[(m_sr[30] & m_sr[29]) * 8 + 2] = d;
      for (int j = 0; j < 16; j++) begin
        sp(6, j[4:0], 32'(15 - j));
        check(op_a_data, opnd(j));
        check(op_b_data, opnd(15 - j));
      end
    end
    $display("test banks end");
    for (int s = 0; s < 16; s++) begin
      prv = s inside {0, 2, 3, 4} || s > 7;
      d = $urandom;
      sp(1, s[4:0], d);
      check({31'h0, priv_violation}, {31'h0, prv});
      sp(0, s[4:0], 32'h0);
      check(sp_rdata, prv ? 32'h0 : d);
    end
    check(status_word, m_sr);
    pcv = $urandom;
    sp(2, 5'h00, pcv);
    sp(0, `CRBRF_SEL_PC, 32'h0);
    check(sp_rdata, pcv + `CRBRF_PC_AHEAD);
    $display("test access end");
    vbv = $urandom;
    d = $urandom;
    apb(1'b1, `CRBRF_W_VBR, vbv);
    sp(3, 5'h00, d);
    check(status_word, m_sr | 32'h70000000);
    check(instruction_pointer, vbv + d);
    sp(0, 5'h0b, 32'h0);
    check(sp_rdata, m_gpr[3]);
    sp(0, `CRBRF_SEL_SPC, 32'h0);
    check(sp_rdata, pcv);
    check({31'h0, priv_violation}, 32'h0);
    rdchk(`CRBRF_W_SSR, m_sr);
    sp(4, 5'h00, 32'h0);
    check(instruction_pointer, pcv);
    @(posedge pclk);
    manual_reset <= 1'b1;
    @(posedge pclk);
    manual_reset <= 1'b0;
    @(negedge pclk);
    check(status_word, `CRBRF_SR_RESET);
    check(instruction_pointer, `CRBRF_PC_RESET);
    rdchk(`CRBRF_W_VBR, `CRBRF_VBR_RESET);
    rdchk(10'h010, m_gpr[16]);
    $display("test exception end");
    close_out();
  end
endmodule
`default_nettype wire
